// File: rtl/rsel_defs.svh
// Offsets, fields, reset values and timing counts of the instance selector
`ifndef RSEL_DEFS_SVH
`define RSEL_DEFS_SVH

// Register byte offsets
`define RSEL_A_IDR 8'h00
`define RSEL_A_VER 8'h04
`define RSEL_A_INST_ID 8'h08
`define RSEL_A_CTRL 8'h0c
`define RSEL_A_PART_SEL 8'h10
`define RSEL_A_CFG_LIM 8'h14
`define RSEL_A_MON_SEL 8'h18
`define RSEL_A_MON_CNT 8'h1c
`define RSEL_A_ERR 8'h20
`define RSEL_A_INT_STAT 8'h24
`define RSEL_A_INT_MASK 8'h28

// Geometry
`define RSEL_NPART 4
`define RSEL_PART_W 2
`define RSEL_NINST 2
`define RSEL_RIS_W 4
`define RSEL_MAX_INSTANCE_VALUE 4'h2
`define RSEL_LIM_W 8

// Selection register fields (partition and monitor selection share them)
`define RSEL_SEL_NS 16
`define RSEL_SEL_RIS_LSB 24

// Feature id fields
`define RSEL_IDR_PARTMAX 16'h0003
`define RSEL_IDR_HAS_MON 1'b1
`define RSEL_IDR_INSTANCE_SELECT_PRESENT 1'b1
`define RSEL_IDR_SP4 1'b0

// Version, major in [7:4], minor in [3:0]
`define RSEL_VER 32'h0000_0010

// Per-instance capability words: bit0 partition, bit1 monitor, [15:8] width
`define RSEL_INST0_ID 32'h0000_0803
`define RSEL_INST1_ID 32'h0000_0801

// Error codes
`define RSEL_ERR_NONE 4'h0
`define RSEL_ERR_NO_CTRL 4'h9
`define RSEL_ERR_RANGE 4'ha

// Reset values
`define RSEL_LIM_RST 8'hff
`define RSEL_THR_RST 1'b1

// Budget window
`define RSEL_CLK_NS 10
`define RSEL_WIN_NS 1000
`define RSEL_WIN_CYC (`RSEL_WIN_NS / `RSEL_CLK_NS)

`endif

// File: rtl/rsel_pkg.sv
// Types of the instance selector
`include "rsel_defs.svh"

package rsel_pkg;

    // Incoming labelled request
    typedef struct packed {
        logic valid;
        logic ns;
        logic [1:0] inst;
        logic [`RSEL_PART_W-1:0] part;
    } rsel_req_t;

    typedef enum logic [0:0] {ST_IDLE, ST_ACT} rsel_st_e;

    typedef logic [1:0][`RSEL_NINST-1:0][`RSEL_NPART-1:0][`RSEL_LIM_W-1:0] rsel_tbl_t;

    // Whole state of the block
    typedef struct packed {
        rsel_st_e st;
        logic wr;
        logic [7:0] addr;
        logic rdy;
        logic resp;
        logic [31:0] rdata;
        logic [`RSEL_PART_W-1:0] selPart;
        logic selNs;
        logic [`RSEL_RIS_W-1:0] selRis;
        logic [`RSEL_PART_W-1:0] monPart;
        logic monNs;
        logic [`RSEL_RIS_W-1:0] monRis;
        logic throttleEn;
        logic [3:0] errCode;
        logic [`RSEL_RIS_W-1:0] errRis;
        logic [1:0] intStat;
        logic [1:0] intMask;
        logic irq;
        logic grant;
        logic deny;
        logic [7:0] winCnt;
        logic [31:0] monCnt;
        rsel_tbl_t lim;
        rsel_tbl_t used;
    } rsel_state_t;

endpackage

// File: rtl/rsel_top.sv
// Resource instance selector with partition budgets and one monitor
`timescale 1ns/1ps
`include "rsel_defs.svh"

module rsel_top (
    input logic clk,
    input logic resetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input rsel_pkg::rsel_req_t req,
    output logic reqGrant,
    output logic reqDeny,
    output logic irq
);
    import rsel_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rstSync_q;
    logic rstn;

    // Two-stage release of the async reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstn = rstSync_q[1];

    // ----------------------------------------
    // State
    // ----------------------------------------
    rsel_state_t s_q, s_d;
    logic [31:0] rd;
    logic evErr;
    logic [3:0] evCode;
    logic selBad, selOk, monBad, cnt;
    logic [`RSEL_LIM_W-1:0] cur;
    logic [7:0] winLast;
    logic accept;

    assign winLast = 8'(`RSEL_WIN_CYC - 1);
    assign accept = hsel && htrans[1] && hready;

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.grant = 1'b0;
        s_d.deny = 1'b0;
        rd = 32'h0;
        evErr = 1'b0;
        evCode = `RSEL_ERR_NONE;
        cur = '0;
        cnt = 1'b0;
        selBad = s_q.selRis > `RSEL_MAX_INSTANCE_VALUE;
        selOk = s_q.selRis < 4'(`RSEL_NINST);
        monBad = s_q.monRis > `RSEL_MAX_INSTANCE_VALUE;

        // Budget window restarts all usage
        if (s_q.winCnt == winLast)
        begin
            s_d.winCnt = 8'h0;
            s_d.used = '0;
        end
        else
            s_d.winCnt = s_q.winCnt + 8'h1;

        // Request admission against the selected limit
        if (req.valid)
        begin
            if (req.inst >= 2'(`RSEL_NINST))
                s_d.deny = 1'b1;
            else
            begin
                cur = s_d.used[req.ns][req.inst[0]][req.part];
                if (!s_q.throttleEn || cur < s_q.lim[req.ns][req.inst[0]][req.part])
                begin
                    s_d.grant = 1'b1;
                    s_d.used[req.ns][req.inst[0]][req.part] = cur + 8'h1;
                end
                else
                    s_d.deny = 1'b1;
            end
        end

        // Monitor of instance 0 counts granted matching traffic
        cnt = s_d.grant && req.inst == 2'h0 && req.part == s_q.monPart
            && req.ns == s_q.monNs;

        // Bus handshake: one wait state per transfer
        if (s_q.st == ST_IDLE)
        begin
            if (accept)
            begin
                s_d.st = ST_ACT;
                s_d.addr = haddr[7:0];
                s_d.wr = hwrite;
                s_d.rdy = 1'b0;
            end
        end
        else
        begin
            s_d.st = ST_IDLE;
            s_d.rdy = 1'b1;
            unique case (s_q.addr)
                `RSEL_A_IDR:
                    rd = {4'h0, `RSEL_MAX_INSTANCE_VALUE, 5'h0, `RSEL_IDR_SP4, `RSEL_IDR_INSTANCE_SELECT_PRESENT,
                        `RSEL_IDR_HAS_MON, `RSEL_IDR_PARTMAX};
                `RSEL_A_VER:
                    rd = `RSEL_VER;
                `RSEL_A_INST_ID:
                begin
                    if (selBad)
                    begin
                        evErr = 1'b1;
                        evCode = `RSEL_ERR_RANGE;
                    end
                    else if (s_q.selRis == 4'h0)
                        rd = `RSEL_INST0_ID;
                    else if (s_q.selRis == 4'h1)
                        rd = `RSEL_INST1_ID;
                end
                `RSEL_A_CTRL:
                begin
                    if (s_q.selRis != 4'h0)
                    begin
                        evErr = 1'b1;
                        evCode = selBad ? `RSEL_ERR_RANGE : `RSEL_ERR_NO_CTRL;
                    end
                    else if (s_q.wr)
                        s_d.throttleEn = hwdata[0];
                    else
                        rd = {31'h0, s_q.throttleEn};
                end
                `RSEL_A_PART_SEL:
                begin
                    if (s_q.wr)
                    begin
                        s_d.selPart = hwdata[`RSEL_PART_W-1:0];
                        s_d.selNs = hwdata[`RSEL_SEL_NS];
                        s_d.selRis = hwdata[`RSEL_SEL_RIS_LSB +: `RSEL_RIS_W];
                    end
                    else
                        rd = {4'h0, s_q.selRis, 7'h0, s_q.selNs, 14'h0, s_q.selPart};
                end
                `RSEL_A_CFG_LIM:
                begin
                    if (selBad)
                    begin
                        evErr = 1'b1;
                        evCode = `RSEL_ERR_RANGE;
                    end
                    else if (!selOk)
                    begin
                        evErr = 1'b1;
                        evCode = `RSEL_ERR_NO_CTRL;
                    end
                    else if (s_q.wr)
                        s_d.lim[s_q.selNs][s_q.selRis[0]][s_q.selPart] =
                            hwdata[`RSEL_LIM_W-1:0];
                    else
                        rd = {24'h0, s_q.lim[s_q.selNs][s_q.selRis[0]][s_q.selPart]};
                end
                `RSEL_A_MON_SEL:
                begin
                    if (s_q.wr)
                    begin
                        s_d.monPart = hwdata[`RSEL_PART_W-1:0];
                        s_d.monNs = hwdata[`RSEL_SEL_NS];
                        s_d.monRis = hwdata[`RSEL_SEL_RIS_LSB +: `RSEL_RIS_W];
                    end
                    else
                        rd = {4'h0, s_q.monRis, 7'h0, s_q.monNs, 14'h0, s_q.monPart};
                end
                `RSEL_A_MON_CNT:
                begin
                    if (monBad || s_q.monRis != 4'h0)
                    begin
                        evErr = 1'b1;
                        evCode = monBad ? `RSEL_ERR_RANGE : `RSEL_ERR_NO_CTRL;
                    end
                    else if (s_q.wr)
                    begin
                        s_d.monCnt = hwdata;
                        cnt = 1'b0;
                    end
                    else
                        rd = s_q.monCnt;
                end
                `RSEL_A_ERR:
                begin
                    if (s_q.wr)
                        s_d.errCode = `RSEL_ERR_NONE;
                    else
                        rd = {20'h0, s_q.errRis, 4'h0, s_q.errCode};
                end
                `RSEL_A_INT_STAT:
                begin
                    if (!s_q.wr)
                    begin
                        rd = {30'h0, s_q.intStat};
                        s_d.intStat = 2'h0;
                    end
                end
                `RSEL_A_INT_MASK:
                begin
                    if (s_q.wr)
                        s_d.intMask = hwdata[1:0];
                    else
                        rd = {30'h0, s_q.intMask};
                end
                default:
                    rd = 32'h0;
            endcase
            if (!s_q.wr)
                s_d.rdata = rd;
        end

        // Monitor count
        if (cnt)
            s_d.monCnt = s_d.monCnt + 32'h1;

        // Error capture, newest wins
        if (evErr)
        begin
            s_d.errCode = evCode;
            s_d.errRis = (s_q.addr == `RSEL_A_MON_CNT) ? s_q.monRis : s_q.selRis;
        end

        // Sticky status: a new event beats the read clear
        s_d.intStat = s_d.intStat | {s_d.deny, evErr};
        s_d.irq = |(s_d.intStat & s_d.intMask);
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.rdy <= 1'b1;
            s_q.throttleEn <= `RSEL_THR_RST;
            s_q.lim <= {(2 * `RSEL_NINST * `RSEL_NPART){`RSEL_LIM_RST}};
        end
        else
            s_q <= s_d;
    end

    // Outputs
    assign hreadyout = s_q.rdy;
    assign hresp = s_q.resp;
    assign hrdata = s_q.rdata;
    assign reqGrant = s_q.grant;
    assign reqDeny = s_q.deny;
    assign irq = s_q.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic act;
    assign act = s_q.st == ST_ACT;

    sequence seqAccept;
        s_q.st == ST_IDLE && accept;
    endsequence

    sequence seqWaitThenReady;
        !hreadyout ##1 hreadyout;
    endsequence

    a_bus_wait_state:
        assert property (seqAccept |=> seqWaitThenReady)
        else $error("transfer did not take exactly one wait state");

    a_version_read:
        assert property (act && !s_q.wr && s_q.addr == `RSEL_A_VER
            |=> hrdata == `RSEL_VER)
        else $error("version word wrong");

    a_idr_fields:
        assert property (act && !s_q.wr && s_q.addr == `RSEL_A_IDR
            |=> hrdata[27:24] == `RSEL_MAX_INSTANCE_VALUE && hrdata[17] && !hrdata[18])
        else $error("feature id fields wrong");

    a_sel_hold:
        assert property (!(act && s_q.wr && s_q.addr == `RSEL_A_PART_SEL)
            |=> $stable(s_q.selRis) && $stable(s_q.selPart) && $stable(s_q.selNs))
        else $error("selection changed without a write");

    a_range_error:
        assert property (act && s_q.addr == `RSEL_A_CFG_LIM && s_q.selRis > `RSEL_MAX_INSTANCE_VALUE
            |=> s_q.errCode == `RSEL_ERR_RANGE && s_q.intStat[0])
        else $error("out of range instance not flagged");

    a_missing_ctrl:
        assert property (act && s_q.addr == `RSEL_A_CFG_LIM && s_q.selRis == 4'h2
            |=> s_q.errCode == `RSEL_ERR_NO_CTRL)
        else $error("missing control not flagged as 9");

    a_common_ctrl:
        assert property (act && s_q.wr && s_q.addr == `RSEL_A_CTRL && s_q.selRis != 4'h0
            |=> $stable(s_q.throttleEn))
        else $error("common control written at nonzero instance");

    a_budget_deny:
        assert property (req.valid && req.inst == 2'h0 && s_q.throttleEn
            && s_q.winCnt != winLast
            && s_q.used[req.ns][0][req.part] >= s_q.lim[req.ns][0][req.part]
            |=> reqDeny && !reqGrant)
        else $error("request over budget was granted");

    a_monitor_count:
        assert property (reqGrant && $past(req.inst) == 2'h0
            && $past(req.part) == $past(s_q.monPart) && $past(req.ns) == $past(s_q.monNs)
            && !($past(act) && $past(s_q.addr) == `RSEL_A_MON_CNT && $past(s_q.wr))
            |-> s_q.monCnt == $past(s_q.monCnt) + 32'h1)
        else $error("monitor missed a matching grant");

    a_budget_grant:
        assert property (req.valid && req.inst == 2'h0 && s_q.throttleEn
            && s_q.winCnt != winLast
            && s_q.used[req.ns][0][req.part] < s_q.lim[req.ns][0][req.part]
            |=> reqGrant && !reqDeny)
        else $error("request within budget was not granted");

    a_unassigned_deny:
        assert property (req.valid && req.inst[1]
            |=> reqDeny && !reqGrant)
        else $error("request to an unassigned instance was granted");

    a_deny_status:
        assert property (reqDeny |-> s_q.intStat[1])
        else $error("deny did not set its status bit");

    a_inst0_word:
        assert property (act && !s_q.wr && s_q.addr == `RSEL_A_INST_ID && s_q.selRis == 4'h0
            |=> hrdata == `RSEL_INST0_ID)
        else $error("instance zero id word wrong");

endmodule

// File: test/rsel_req_model.sv
// Requester model that issues one labelled request per command
`timescale 1ns/1ps

module rsel_req_model (
    input logic clk,
    input logic issue,
    input logic issNs,
    input logic [1:0] issInst,
    input logic [1:0] issPart,
    output rsel_pkg::rsel_req_t req
);
    import rsel_pkg::*;

    // ----------------------------------------
    // Request driver
    // ----------------------------------------
    initial req = '0;

    // One label per command; idle fields invert so stale labels match only on every second idle cycle
    always @(posedge clk)
    begin
        if (issue)
            req <= '{valid: 1'b1, ns: issNs, inst: issInst, part: issPart};
        else
            req <= '{valid: 1'b0, ns: ~req.ns, inst: ~req.inst, part: ~req.part};
    end
endmodule

// File: test/tb.sv
// Self-checking bench of the instance selector: bus, selection, budgets, interrupt
`timescale 1ns/1ps
`include "rsel_defs.svh"

module tb;
    import rsel_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, resetn, hwrite, issue, issNs, hreadyout, hresp, reqGrant, reqDeny, irq;
    logic [1:0] htrans, issInst, issPart;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    rsel_req_t req;
    int fails = 0;
    int samplesChecked = 0;

    // ----------------------------------------
    // Instances
    // ----------------------------------------
    rsel_top DUT (.clk(clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req),
        .reqGrant(reqGrant), .reqDeny(reqDeny), .irq(irq));

    rsel_req_model partner (.clk(clk), .issue(issue), .issNs(issNs), .issInst(issInst),
        .issPart(issPart), .req(req));

    // Clock of 10 ns
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("dataEdges", 32'h2, n);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, exp, rdv);
    endtask

    function automatic logic [31:0] sel(input logic ns, input logic [3:0] resource_instance_selector,
        input logic [1:0] part);
        return {4'h0, resource_instance_selector, 7'h0, ns, 14'h0, part};
    endfunction

    // One request, then judge the one-cycle answer
    task automatic rq(input logic ns, input logic [1:0] inst, input logic [1:0] part,
        input logic g);
        @(posedge clk);
        issue <= 1'b1;
        issNs <= ns;
        issInst <= inst;
        issPart <= part;
        @(posedge clk);
        issue <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reqGrant", {31'h0, g}, {31'h0, reqGrant});
        chk("reqDeny", {31'h0, ~g}, {31'h0, reqDeny});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ident();
        rdc("idr", `RSEL_A_IDR, 32'h0203_0003);
        rdc("ver", `RSEL_A_VER, 32'h0000_0010);
        rdc("unmapped", 8'h3c, 32'h0);
    endtask

    task automatic t_inst();
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h1, 2'h0));
        rdc("inst1", `RSEL_A_INST_ID, 32'h0000_0801);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h2, 2'h0));
        rdc("inst2", `RSEL_A_INST_ID, 32'h0);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h3, 2'h0));
        rdc("inst3", `RSEL_A_INST_ID, 32'h0);
        rdc("errRange", `RSEL_A_ERR, 32'h0000_030a);
        bus(1'b1, `RSEL_A_ERR, 32'h0);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h0, 2'h0));
        rdc("inst0", `RSEL_A_INST_ID, 32'h0000_0803);
    endtask

    task automatic t_limit();
        rdc("limRst", `RSEL_A_CFG_LIM, 32'h0000_00ff);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b1, 4'h1, 2'h2));
        bus(1'b1, `RSEL_A_CFG_LIM, 32'h0000_005a);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h1, 2'h2));
        bus(1'b1, `RSEL_A_CFG_LIM, 32'h0000_0033);
        rdc("limSec", `RSEL_A_CFG_LIM, 32'h0000_0033);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b1, 4'h1, 2'h2));
        rdc("limNs", `RSEL_A_CFG_LIM, 32'h0000_005a);
        rdc("limHold", `RSEL_A_CFG_LIM, 32'h0000_005a);
        rdc("partSel", `RSEL_A_PART_SEL, sel(1'b1, 4'h1, 2'h2));
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h2, 2'h0));
        rdc("limNoCtrl", `RSEL_A_CFG_LIM, 32'h0);
        rdc("errNoCtrl", `RSEL_A_ERR, 32'h0000_0209);
        bus(1'b1, `RSEL_A_ERR, 32'h0);
    endtask

    task automatic t_ctrl_irq();
        rdc("statClr", `RSEL_A_INT_STAT, 32'h0000_0001);
        bus(1'b1, `RSEL_A_INT_MASK, 32'h0000_0001);
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h1, 2'h0));
        bus(1'b1, `RSEL_A_CTRL, 32'h0);
        rdc("errCommon", `RSEL_A_ERR, 32'h0000_0109);
        repeat (2) @(posedge clk);
        chk("irqSet", 32'h1, {31'h0, irq});
        rdc("statErr", `RSEL_A_INT_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("irqClr", 32'h0, {31'h0, irq});
        bus(1'b1, `RSEL_A_INT_MASK, 32'h0);
        bus(1'b1, `RSEL_A_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("irqMasked", 32'h0, {31'h0, irq});
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b0, 4'h0, 2'h0));
        rdc("ctrlKept", `RSEL_A_CTRL, 32'h0000_0001);
        rdc("statMask", `RSEL_A_INT_STAT, 32'h0000_0001);
        bus(1'b1, `RSEL_A_ERR, 32'h0);
    endtask

    task automatic t_req();
        bus(1'b1, `RSEL_A_PART_SEL, sel(1'b1, 4'h0, 2'h1));
        bus(1'b1, `RSEL_A_CFG_LIM, 32'h0);
        bus(1'b1, `RSEL_A_MON_SEL, sel(1'b0, 4'h0, 2'h1));
        bus(1'b1, `RSEL_A_MON_CNT, 32'h0);
        bus(1'b1, `RSEL_A_INT_MASK, 32'h0000_0002);
        rq(1'b0, 2'h0, 2'h1, 1'b1);
        rq(1'b1, 2'h0, 2'h1, 1'b0);
        rq(1'b0, 2'h2, 2'h1, 1'b0);
        rq(1'b0, 2'h1, 2'h1, 1'b1);
        chk("irqDeny", 32'h1, {31'h0, irq});
        rdc("monCnt", `RSEL_A_MON_CNT, 32'h0000_0001);
        rdc("statDeny", `RSEL_A_INT_STAT, 32'h0000_0002);
        bus(1'b1, `RSEL_A_MON_SEL, sel(1'b0, 4'h1, 2'h1));
        rdc("monNone", `RSEL_A_MON_CNT, 32'h0);
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the 48 transfers of the run
    initial
    begin
        #200000;
        fails++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        resetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        issue = 1'b0;
        issNs = 1'b0;
        issInst = 2'h0;
        issPart = 2'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("irqRst", 32'h0, {31'h0, irq});
        t_ident();
        t_inst();
        t_limit();
        t_ctrl_irq();
        t_req();
        end_sim();
    end
endmodule
